// ==== logic/sbg_top.sv ====
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Refuse services with boot-protected keys unless boot tag matched.
// - Debug challenge/authorize work only when no key is write-protected.
// - Successful debug authorize erases the whole user-key area.
// - Load-plain-key copies host key into the volatile key slot.
// - Parallel mode releases core together with engine boot authentication.
// - Parallel mode allows clock switching while authentication continues.
// - Sequential mode gates core clock until authentication completes.
// - Sequential mode timeout of 16M oscillator cycles releases core.
// - Sequential mode blocks clock switching until authentication ends.
// - Erased shadow words default to parallel mode.
// - Sequential mode needs the start marker value at its offset.
// - Option word bit zero low selects sequential, high keeps parallel.
// - Wake into RAM skips authentication; protected keys stay unusable.
// - Initialise command loads firmware and copies valid stored keys.
// - Software issue of the boot authentication command is rejected.
// - Wake through flash boot repeats full authentication sequence.
// - Boot-ok set only when computed tag equals stored boot tag.
module sbg_top #(
   parameter int TIMEOUT_TICKS = sbg_pkg::TIMEOUT_IRC_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_from_flash_pin,
   input wire logic wake_pin,
   input wire logic auth_done,
   input wire logic auth_match,
   input wire logic eng_done,
   input wire logic eng_ok,
   input wire logic wp_any,
   input wire logic [15:0] bp_slots,
   input wire logic [1:0] key_rd_addr,
   output logic [31:0] key_rd_data,
   output logic auth_start,
   output logic eng_req,
   output logic [3:0] eng_op,
   output logic [3:0] eng_key_sel,
   output logic erase_user_keys,
   output logic core_rst_release,
   output logic core_clk_en,
   output logic clk_switch_allow,
   output logic boot_ok
);
   typedef enum logic [2:0] {
      B_POR = 3'b000,
      B_EVAL = 3'b001,
      B_AUTH = 3'b010,
      B_RUN = 3'b011
   } sbg_boot_t;
   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_LOAD = 2'b01,
      C_WAIT = 2'b10
   } sbg_cmd_t;

   // Pin synchronisers; stage one feeds only stage two
   logic [1:0] flash_s;
   logic [2:0] wake_s;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_s <= '0;
         wake_s <= '0;
      end else begin
         flash_s <= {flash_s[0], boot_from_flash_pin};
         wake_s <= {wake_s[1:0], wake_pin};
      end
   end
   logic boot_flash;
   logic wake_evt;
   assign boot_flash = flash_s[1];
   assign wake_evt = wake_s[1] && !wake_s[2];

   // APB register state
   logic [31:0] start_mark_r, start_mark_nxt, user_opt_r, user_opt_nxt;
   logic [31:0] stop_mark_r, stop_mark_nxt;
   logic [31:0] p_r [sbg_pkg::KEY_WORDS];
   logic [31:0] p_nxt [sbg_pkg::KEY_WORDS];
   logic [31:0] prdata_nxt;
   logic pready_nxt, pslverr_nxt, wr_acc, cmd_wr;
   logic [3:0] err_r, err_nxt;
   logic [31:0] status;
   logic busy;

   function automatic logic mapped(input logic [7:0] a);
      mapped = a inside {sbg_pkg::OFF_CMD, sbg_pkg::OFF_STAT, sbg_pkg::OFF_ERR,
                         sbg_pkg::OFF_START_MARK, sbg_pkg::OFF_USER_OPT,
                         sbg_pkg::OFF_STOP_MARK, sbg_pkg::OFF_P1, sbg_pkg::OFF_P2,
                         sbg_pkg::OFF_P3, sbg_pkg::OFF_P4};
   endfunction

   // Read data is captured in setup so pready can come from a flop; no wait states
   always_comb begin
      wr_acc = psel && penable && pready && pwrite;
      cmd_wr = wr_acc && paddr == sbg_pkg::OFF_CMD;
      pready_nxt = psel && !penable;
      pslverr_nxt = psel && !penable && !mapped(paddr);
      prdata_nxt = prdata;
      start_mark_nxt = start_mark_r;
      user_opt_nxt = user_opt_r;
      stop_mark_nxt = stop_mark_r;
      p_nxt = p_r;
      if (psel && !penable) begin
         case (paddr)
            sbg_pkg::OFF_STAT: prdata_nxt = status;
            sbg_pkg::OFF_ERR: prdata_nxt = {28'h000_0000, err_r};
            sbg_pkg::OFF_START_MARK: prdata_nxt = start_mark_r;
            sbg_pkg::OFF_USER_OPT: prdata_nxt = user_opt_r;
            sbg_pkg::OFF_STOP_MARK: prdata_nxt = stop_mark_r;
            sbg_pkg::OFF_P1: prdata_nxt = p_r[0];
            sbg_pkg::OFF_P2: prdata_nxt = p_r[1];
            sbg_pkg::OFF_P3: prdata_nxt = p_r[2];
            sbg_pkg::OFF_P4: prdata_nxt = p_r[3];
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
      // Parameters are writable only while idle; writes during busy are dropped
      if (wr_acc && !busy) begin
         case (paddr)
            sbg_pkg::OFF_START_MARK: start_mark_nxt = pwdata;
            sbg_pkg::OFF_USER_OPT: user_opt_nxt = pwdata;
            sbg_pkg::OFF_STOP_MARK: stop_mark_nxt = pwdata;
            sbg_pkg::OFF_P1: p_nxt[0] = pwdata;
            sbg_pkg::OFF_P2: p_nxt[1] = pwdata;
            sbg_pkg::OFF_P3: p_nxt[2] = pwdata;
            sbg_pkg::OFF_P4: p_nxt[3] = pwdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         start_mark_r <= sbg_pkg::SHADOW_ERASED;
         user_opt_r <= sbg_pkg::SHADOW_ERASED;
         stop_mark_r <= sbg_pkg::SHADOW_ERASED;
         p_r <= '{default: '0};
      end else begin
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         start_mark_r <= start_mark_nxt;
         user_opt_r <= user_opt_nxt;
         stop_mark_r <= stop_mark_nxt;
         p_r <= p_nxt;
      end
   end

   // Boot sequencing
   sbg_boot_t b_st, b_nxt;
   logic [1:0] settle_r, settle_nxt;
   logic seq_r, seq_nxt, tmo_r, tmo_nxt, expired;
   logic rel_nxt, clk_nxt, sw_nxt, ok_nxt, start_nxt;

   sbg_timeout #(.LIMIT(TIMEOUT_TICKS)) u_tmo (
      .pclk(pclk),
      .presetn(presetn),
      .run(b_st == B_AUTH && seq_r),
      .expired(expired)
   );

   always_comb begin
      b_nxt = b_st;
      settle_nxt = settle_r;
      seq_nxt = seq_r;
      tmo_nxt = tmo_r;
      rel_nxt = core_rst_release;
      clk_nxt = core_clk_en;
      sw_nxt = clk_switch_allow;
      ok_nxt = boot_ok;
      start_nxt = 1'b0;
      case (b_st)
         // Strap is read only after the synchroniser has filled
         B_POR: begin
            settle_nxt = settle_r + 2'h1;
            if (settle_r == 2'(sbg_pkg::SYNC_SETTLE)) begin
               b_nxt = B_EVAL;
            end
         end
         B_EVAL: begin
            ok_nxt = 1'b0;
            tmo_nxt = 1'b0;
            rel_nxt = 1'b1;
            b_nxt = B_RUN;
            clk_nxt = 1'b1;
            sw_nxt = 1'b1;
            if (boot_flash) begin
               seq_nxt = start_mark_r == sbg_pkg::START_MARK_SEQ &&
                         !user_opt_r[sbg_pkg::RUN_MODE_BIT];
               start_nxt = 1'b1;
               b_nxt = B_AUTH;
               if (seq_nxt) begin
                  clk_nxt = 1'b0;
                  sw_nxt = 1'b0;
               end
            end
         end
         B_AUTH: begin
            if (auth_done) begin
               ok_nxt = auth_match;
               clk_nxt = 1'b1;
               sw_nxt = 1'b1;
               b_nxt = B_RUN;
            end else if (expired) begin
               ok_nxt = 1'b0;
               tmo_nxt = 1'b1;
               clk_nxt = 1'b1;
               sw_nxt = 1'b1;
               b_nxt = B_RUN;
            end
         end
         B_RUN: begin
            if (wake_evt) begin
               rel_nxt = 1'b0;
               clk_nxt = 1'b0;
               b_nxt = B_EVAL;
            end
         end
         default: b_nxt = B_POR;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_st <= B_POR;
         settle_r <= '0;
         seq_r <= 1'b0;
         tmo_r <= 1'b0;
         core_rst_release <= 1'b0;
         core_clk_en <= 1'b0;
         clk_switch_allow <= 1'b0;
         boot_ok <= 1'b0;
         auth_start <= 1'b0;
      end else begin
         b_st <= b_nxt;
         settle_r <= settle_nxt;
         seq_r <= seq_nxt;
         tmo_r <= tmo_nxt;
         core_rst_release <= rel_nxt;
         core_clk_en <= clk_nxt;
         clk_switch_allow <= sw_nxt;
         boot_ok <= ok_nxt;
         auth_start <= start_nxt;
      end
   end

   // Command engine
   sbg_cmd_t c_st, c_nxt;
   sbg_pkg::sbg_op_t op_r, op_nxt, new_op;
   logic [1:0] ld_r, ld_nxt;
   logic kv_r, kv_nxt, req_nxt, erase_nxt;
   logic [3:0] sel_nxt;

   assign new_op = sbg_pkg::sbg_op_t'(pwdata[3:0]);
   assign busy = c_st != C_IDLE;

   always_comb begin
      c_nxt = c_st;
      op_nxt = op_r;
      ld_nxt = ld_r;
      kv_nxt = kv_r;
      err_nxt = err_r;
      req_nxt = 1'b0;
      erase_nxt = 1'b0;
      sel_nxt = eng_key_sel;
      case (c_st)
         C_IDLE: begin
            if (cmd_wr) begin
               op_nxt = new_op;
               err_nxt = sbg_pkg::ERR_NONE;
               sel_nxt = p_r[0][3:0];
               case (new_op)
                  sbg_pkg::SBG_OP_LOAD_PLAIN: begin
                     ld_nxt = '0;
                     kv_nxt = 1'b0;
                     c_nxt = C_LOAD;
                  end
                  sbg_pkg::SBG_OP_INIT: begin
                     req_nxt = 1'b1;
                     c_nxt = C_WAIT;
                  end
                  sbg_pkg::SBG_OP_DBG_CHAL, sbg_pkg::SBG_OP_DBG_AUTH: begin
                     if (wp_any) begin
                        err_nxt = sbg_pkg::ERR_REFUSED;
                     end else begin
                        req_nxt = 1'b1;
                        c_nxt = C_WAIT;
                     end
                  end
                  sbg_pkg::SBG_OP_GEN_TAG: begin
                     if (bp_slots[p_r[0][3:0]] && !boot_ok) begin
                        err_nxt = sbg_pkg::ERR_KEY_LOCKED;
                     end else begin
                        req_nxt = 1'b1;
                        c_nxt = C_WAIT;
                     end
                  end
                  sbg_pkg::SBG_OP_SECURE_BOOT: err_nxt = sbg_pkg::ERR_REFUSED;
                  default: err_nxt = sbg_pkg::ERR_BAD_CMD;
               endcase
            end
         end
         C_LOAD: begin
            ld_nxt = ld_r + 2'h1;
            if (ld_r == 2'(sbg_pkg::KEY_WORDS - 1)) begin
               kv_nxt = 1'b1;
               c_nxt = C_IDLE;
            end
         end
         C_WAIT: begin
            if (eng_done) begin
               c_nxt = C_IDLE;
               if (!eng_ok) begin
                  err_nxt = sbg_pkg::ERR_ENGINE;
               end else if (op_r == sbg_pkg::SBG_OP_DBG_AUTH) begin
                  erase_nxt = 1'b1;
                  kv_nxt = 1'b0;
               end
            end
         end
         default: c_nxt = C_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c_st <= C_IDLE;
         op_r <= sbg_pkg::SBG_OP_NONE;
         ld_r <= '0;
         kv_r <= 1'b0;
         err_r <= sbg_pkg::ERR_NONE;
         eng_req <= 1'b0;
         erase_user_keys <= 1'b0;
         eng_key_sel <= '0;
      end else begin
         c_st <= c_nxt;
         op_r <= op_nxt;
         ld_r <= ld_nxt;
         kv_r <= kv_nxt;
         err_r <= err_nxt;
         eng_req <= req_nxt;
         erase_user_keys <= erase_nxt;
         eng_key_sel <= sel_nxt;
      end
   end
   assign eng_op = op_r;

   // Volatile key slot written word by word from the parameter registers
   sbg_key_ram #(.WIDTH(32), .DEPTH(sbg_pkg::KEY_WORDS), .AW(2)) u_key (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(c_st == C_LOAD),
      .wr_addr(ld_r),
      .wr_data(p_r[ld_r]),
      .rd_addr(key_rd_addr),
      .rd_data(key_rd_data)
   );

   always_comb begin
      status = '0;
      status[sbg_pkg::ST_BUSY] = busy;
      status[sbg_pkg::ST_BOOT_OK] = boot_ok;
      status[sbg_pkg::ST_SEQ] = seq_r;
      status[sbg_pkg::ST_AUTH] = b_st == B_AUTH;
      status[sbg_pkg::ST_KEY_VALID] = kv_r;
      status[sbg_pkg::ST_TIMED_OUT] = tmo_r;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_bp_key_refused: assert property (c_st == C_IDLE && cmd_wr &&
      new_op == sbg_pkg::SBG_OP_GEN_TAG && bp_slots[p_r[0][3:0]] && !boot_ok
      |=> !eng_req && err_r == sbg_pkg::ERR_KEY_LOCKED) else $error("protected key used");
   a_dbg_wp_block: assert property (c_st == C_IDLE && cmd_wr && wp_any &&
      new_op == sbg_pkg::SBG_OP_DBG_AUTH |=> !eng_req && !busy) else $error("debug ran");
   a_erase_after_auth: assert property (c_st == C_WAIT && eng_done && eng_ok &&
      op_r == sbg_pkg::SBG_OP_DBG_AUTH |=> erase_user_keys ##1 !erase_user_keys)
      else $error("no erase pulse");
   a_load_plain_slot: assert property (c_st == C_IDLE && cmd_wr &&
      new_op == sbg_pkg::SBG_OP_LOAD_PLAIN |=> busy [*4] ##1 (kv_r && !busy))
      else $error("key load length");
   a_parallel_release: assert property (b_st == B_EVAL && boot_flash && !seq_nxt
      |=> core_rst_release && core_clk_en && clk_switch_allow && auth_start)
      else $error("parallel release");
   a_seq_gate_hold: assert property (b_st == B_AUTH && seq_r
      |-> !core_clk_en && !clk_switch_allow) else $error("seq clock leak");
   a_timeout_no_ok: assert property (b_st == B_AUTH && seq_r && expired && !auth_done
      |=> core_clk_en && !boot_ok && tmo_r) else $error("timeout release");
   a_ram_wake_skip: assert property (b_st == B_EVAL && !boot_flash
      |=> !boot_ok && !auth_start && core_clk_en) else $error("ram wake auth");
   a_boot_cmd_reject: assert property (c_st == C_IDLE && cmd_wr &&
      new_op == sbg_pkg::SBG_OP_SECURE_BOOT |=> err_r == sbg_pkg::ERR_REFUSED && !eng_req)
      else $error("boot cmd accepted");
   a_bootok_match: assert property (b_st == B_AUTH && auth_done
      |=> boot_ok == $past(auth_match)) else $error("boot ok mismatch");

   c_seq_boot: cover property (b_st == B_AUTH && seq_r && auth_done && auth_match);
   c_seq_timeout: cover property (b_st == B_AUTH && seq_r && expired);
   c_key_erase: cover property (erase_user_keys);
   c_flash_wake: cover property (b_st == B_RUN && wake_evt);
endmodule

// ==== logic/sbg_pkg.sv ====
package sbg_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_ERR = 8'h08;
   localparam logic [7:0] OFF_START_MARK = 8'h10;
   localparam logic [7:0] OFF_USER_OPT = 8'h20;
   localparam logic [7:0] OFF_STOP_MARK = 8'h30;
   localparam logic [7:0] OFF_P1 = 8'h40;
   localparam logic [7:0] OFF_P2 = 8'h44;
   localparam logic [7:0] OFF_P3 = 8'h48;
   localparam logic [7:0] OFF_P4 = 8'h4c;
   // Shadow words read erased after reset, as shipped
   localparam logic [31:0] SHADOW_ERASED = 32'hffff_ffff;
   localparam logic [31:0] START_MARK_SEQ = 32'h05aa_55af;
   localparam int RUN_MODE_BIT = 0;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_BOOT_OK = 1;
   localparam int ST_SEQ = 2;
   localparam int ST_AUTH = 3;
   localparam int ST_KEY_VALID = 4;
   localparam int ST_TIMED_OUT = 5;
   // Engine command codes
   typedef enum logic [3:0] {
      SBG_OP_NONE = 4'h0,
      SBG_OP_INIT = 4'h1,
      SBG_OP_LOAD_PLAIN = 4'h2,
      SBG_OP_DBG_CHAL = 4'h3,
      SBG_OP_DBG_AUTH = 4'h4,
      SBG_OP_SECURE_BOOT = 4'h5,
      SBG_OP_GEN_TAG = 4'h6
   } sbg_op_t;
   // Error codes
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_REFUSED = 4'h1;
   localparam logic [3:0] ERR_KEY_LOCKED = 4'h2;
   localparam logic [3:0] ERR_BAD_CMD = 4'h3;
   localparam logic [3:0] ERR_ENGINE = 4'h4;
   // Timing: internal RC oscillator against pclk
   localparam int PCLK_MHZ = 100;
   localparam int IRC_MHZ = 16;
   localparam int TIMEOUT_IRC_TICKS = 16777216;
   localparam int SYNC_SETTLE = 3;
   localparam int KEY_WORDS = 4;
endpackage

// ==== logic/sbg_key_ram.sv ====
`timescale 1ns/1ps
// Volatile key slot storage; read data leaves through a register
module sbg_key_ram #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Array has no reset; only the read register does
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ==== logic/sbg_timeout.sv ====
`timescale 1ns/1ps
// Counts oscillator-rate ticks while run is high; expired is a level
module sbg_timeout #(
   parameter int LIMIT = sbg_pkg::TIMEOUT_IRC_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   output logic expired
);
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic tick;

   // Fractional divider: 16 ticks per 100 pclk cycles, no second clock needed
   always_comb begin
      acc_nxt = acc_r + 8'(sbg_pkg::IRC_MHZ);
      tick = 1'b0;
      if (acc_nxt >= 8'(sbg_pkg::PCLK_MHZ)) begin
         acc_nxt = acc_nxt - 8'(sbg_pkg::PCLK_MHZ);
         tick = 1'b1;
      end
      cnt_nxt = cnt_r;
      if (!run) begin
         cnt_nxt = '0;
         acc_nxt = '0;
      end else if (tick && cnt_r != 32'(LIMIT)) begin
         cnt_nxt = cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= '0;
         cnt_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign expired = run && (cnt_r == 32'(LIMIT));
endmodule

// ==== verif/sbg_eng_model.sv ====
`timescale 1ns/1ps
// Engine stand-in: answers each request, and each start made while hang is low, after a set delay
module sbg_eng_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic auth_start,
   input wire logic eng_req,
   input wire logic [7:0] dly,
   input wire logic mat,
   input wire logic hang,
   input wire logic ok,
   output logic auth_done,
   output logic auth_match,
   output logic eng_done,
   output logic eng_ok
);
   int ac;
   int ec;
   // Qualifiers toggle outside done, so no check can lean on a stale level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ac <= 0;
         ec <= 0;
         auth_done <= 0;
         eng_done <= 0;
         auth_match <= 0;
         eng_ok <= 0;
      end else begin
         auth_done <= 0;
         eng_done <= 0;
         auth_match <= ~auth_match;
         eng_ok <= ~eng_ok;
         if (auth_start && !hang) ac <= dly;
         else if (ac == 1) begin
            auth_done <= 1;
            auth_match <= mat;
            ac <= 0;
         end else if (ac != 0) ac <= ac - 1;
         if (eng_req) ec <= 3;
         else if (ec == 1) begin
            eng_done <= 1;
            eng_ok <= ok;
            ec <= 0;
         end else if (ec != 0) ec <= ec - 1;
      end
   end
endmodule

// ==== verif/secure_boot_run_mode_gating_tb.sv ====
`timescale 1ns/1ps
// Bench: APB host, engine model, reference counters
module secure_boot_run_mode_gating_tb;
   localparam int TO = 8;
   localparam int TW = TO * 100 / 16;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, key_rd_data, rd, opt;
   logic pready, pslverr, se, auth_done, auth_match, eng_done, eng_ok, auth_start, eng_req;
   logic flash = 1, wake_pin = 0, wp_any = 0, mat = 1, hang = 0, ok = 1;
   logic [15:0] bp_slots = 16'h0002;
   logic [1:0] key_rd_addr = 2'h0;
   logic [7:0] dly = 8'h14;
   logic [7:0] offs [3];
   logic [3:0] eng_op, eng_key_sel;
   logic erase_user_keys, core_rst_release, core_clk_en, clk_switch_allow, boot_ok;
   int error_cnt = 0, tests_run = 0, n_auth = 0, n_req = 0, n_er = 0, wn, ea, er, i, seed;
   logic [31:0] kq [$];
   int opt_t [4] = '{5, 1, 1, 7};
   int ok_t [4] = '{1, 0, 1, 1};
   int err_t [4] = '{1, 4, 0, 3};
   int req_t [4] = '{0, 1, 1, 0};

   sbg_top #(.TIMEOUT_TICKS(TO)) u_sbg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_from_flash_pin(flash), .wake_pin(wake_pin),
      .auth_done(auth_done), .auth_match(auth_match), .eng_done(eng_done), .eng_ok(eng_ok),
      .wp_any(wp_any), .bp_slots(bp_slots), .key_rd_addr(key_rd_addr),
      .key_rd_data(key_rd_data), .auth_start(auth_start), .eng_req(eng_req), .eng_op(eng_op),
      .eng_key_sel(eng_key_sel), .erase_user_keys(erase_user_keys),
      .core_rst_release(core_rst_release), .core_clk_en(core_clk_en),
      .clk_switch_allow(clk_switch_allow), .boot_ok(boot_ok));
   sbg_eng_model u_sbg_eng_model (.pclk(pclk), .presetn(presetn), .auth_start(auth_start),
      .eng_req(eng_req), .dly(dly), .mat(mat), .hang(hang), .ok(ok), .auth_done(auth_done),
      .auth_match(auth_match), .eng_done(eng_done), .eng_ok(eng_ok));

   always #5 pclk = ~pclk;
   // Pulse counters stand in for the expected side effects
   always @(posedge pclk) begin
      if (auth_start === 1'b1) n_auth++;
      if (eng_req === 1'b1) n_req++;
      if (erase_user_keys === 1'b1) n_er++;
   end

   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task cmd(input logic [3:0] op);
      do apb(0, sbg_pkg::OFF_STAT, 0); while (rd[sbg_pkg::ST_BUSY] !== 1'b0 && wn++ < 900);
      apb(1, sbg_pkg::OFF_CMD, {28'h0, op});
      do apb(0, sbg_pkg::OFF_STAT, 0); while (rd[sbg_pkg::ST_BUSY] !== 1'b0 && wn++ < 900);
      apb(0, sbg_pkg::OFF_ERR, 0);
   endtask

   task wt(input int s, input logic v);
      wn = 0;
      while ((s == 0 ? core_rst_release : s == 1 ? core_clk_en : boot_ok) !== v && wn < 300) begin
         @(negedge pclk);
         wn++;
      end
   endtask

   // Wake is ignored mid-authentication, so let a running one end first
   task wake();
      do apb(0, sbg_pkg::OFF_STAT, 0); while (rd[sbg_pkg::ST_AUTH] !== 1'b0);
      @(posedge pclk);
      wake_pin <= 1;
      @(posedge pclk);
      wake_pin <= 0;
      wt(0, 0);
      wt(0, 1);
      ea = n_auth;
   endtask

   task report_and_stop();
      $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      seed = 32'h5456;
      offs = '{sbg_pkg::OFF_START_MARK, sbg_pkg::OFF_USER_OPT, sbg_pkg::OFF_STOP_MARK};
      repeat (5) @(posedge pclk);
      presetn <= 1;
      wt(0, 1);
      chk("par_rel", {core_rst_release, core_clk_en, clk_switch_allow, boot_ok}, 4'b1110);
      apb(0, sbg_pkg::OFF_STAT, 0);
      chk("par_auth", {clk_switch_allow, rd[3:1]}, 4'b1100);
      for (i = 0; i < 3; i++) begin
         apb(0, offs[i], 0);
         chk("shadow_rst", rd, sbg_pkg::SHADOW_ERASED);
      end
      wt(2, 1);
      chk("par_ok", {boot_ok, n_auth[3:0]}, 5'h11);
      apb(1, 8'h50, 32'h1);
      chk("unmapped", {se, rd[30:0]}, 32'h80000000);
      $display("test power_on done");
      for (i = 0; i < 4; i++) begin
         kq.push_back($random(seed));
         apb(1, sbg_pkg::OFF_P1 + 8'(4 * i), kq[i]);
      end
      cmd(sbg_pkg::SBG_OP_LOAD_PLAIN);
      for (i = 0; i < 4; i++) begin
         key_rd_addr <= 2'(i);
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         chk("key_word", key_rd_data, kq[i]);
         @(posedge pclk);
      end
      bp_slots <= 16'($random(seed)) | 16'h0002;
      apb(1, sbg_pkg::OFF_P1, 32'h1);
      apb(1, sbg_pkg::OFF_P2, 32'h1000 * 8);
      apb(1, sbg_pkg::OFF_P3, 32'h10);
      er = n_req;
      cmd(sbg_pkg::SBG_OP_GEN_TAG);
      chk("tag_go", {eng_key_sel, eng_op, rd[3:0], 4'(n_req - er)}, 16'h1601);
      for (i = 0; i < 4; i++) begin
         ok <= ok_t[i][0];
         er = n_req;
         cmd(4'(opt_t[i]));
         chk("op_err", {rd[3:0], 4'(n_req - er)}, {4'(err_t[i]), 4'(req_t[i])});
      end
      wp_any <= 1;
      cmd(sbg_pkg::SBG_OP_DBG_CHAL);
      cmd(sbg_pkg::SBG_OP_DBG_AUTH);
      chk("dbg_lock", {rd[3:0], 4'(n_er)}, {sbg_pkg::ERR_REFUSED, 4'h0});
      wp_any <= 0;
      cmd(sbg_pkg::SBG_OP_DBG_CHAL);
      cmd(sbg_pkg::SBG_OP_DBG_AUTH);
      apb(0, sbg_pkg::OFF_STAT, 0);
      chk("dbg_erase", {rd[sbg_pkg::ST_KEY_VALID], 4'(n_er)}, 5'h01);
      $display("test commands done");
      for (i = 0; i < 3; i++) begin
         opt = $random(seed);
         apb(1, offs[0], i == 0 ? opt : sbg_pkg::START_MARK_SEQ);
         apb(1, offs[1], i == 1 ? opt | 1 : opt & ~32'h1);
         apb(0, offs[1], 0);
         chk("opt_rb", rd, i == 1 ? opt | 1 : opt & ~32'h1);
         mat <= 0;
         wake();
         chk("mode", {core_clk_en, clk_switch_allow}, i == 2 ? 2'b00 : 2'b11);
      end
      wt(1, 1);
      chk("seq_bad", {boot_ok, 4'(n_auth - ea)}, 5'h01);
      cmd(sbg_pkg::SBG_OP_GEN_TAG);
      chk("locked", rd[3:0], sbg_pkg::ERR_KEY_LOCKED);
      hang <= 1;
      wake();
      wt(1, 1);
      chk("to_wait", 32'(wn >= TW - 8 && wn <= TW + 8), 1);
      apb(0, sbg_pkg::OFF_STAT, 0);
      chk("to_flags", {boot_ok, rd[sbg_pkg::ST_TIMED_OUT]}, 2'b01);
      hang <= 0;
      mat <= 1;
      flash <= 0;
      wake();
      repeat (30) @(negedge pclk);
      chk("ram_wake", {boot_ok, core_clk_en, 4'(n_auth - ea)}, 6'h10);
      @(posedge pclk);
      flash <= 1;
      wake();
      wt(1, 1);
      chk("flash_wake", {boot_ok, 4'(n_auth - ea)}, 5'h11);
      $display("test run modes done");
      report_and_stop();
   end
endmodule
